// File: design/ptb_timebase.sv
// pwm time base: 12-bit up or up/down counter with scalers and apb regs
// assumes apb3 master on CORE_CLK_IN; all inputs synchronous to it
`timescale 1ns/100ps
module ptb_timebase (
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RSTN_IN,
  // apb slave
  input wire logic [7:0] PADDR_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // to compare and output logic
  output logic [11:0] COUNT_OUT,
  output logic COUNT_DOWN_OUT,
  output logic ZERO_MATCH_OUT,
  output logic PERIOD_MATCH_OUT,
  output logic OUTPUT_ALLOW_OUT,
  // sticky event flag
  output logic IRQ_FLAG_OUT
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] count;
    logic dir;
    logic run;
    ptb_pkg::ptb_mode_t mode;
    logic [1:0] presc_sel;
    logic [3:0] post_sel;
    logic [11:0] per_buf;
    logic [11:0] per_act;
    logic [5:0] presc_cnt;
    logic [3:0] post_cnt;
    logic irq;
    logic allow;
    logic zero_stb;
    logic per_stb;
    logic [31:0] prdata;
    logic pready;
    logic slverr;
  } ptb_state_t;

  ptb_state_t cur_ff;
  ptb_state_t nxt_st;

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  function automatic logic [31:0] rd_word(input ptb_state_t s,
                                          input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      ptb_pkg::OFS_CTRL_A: begin
        w[ptb_pkg::POS_POST +: 4] = s.post_sel;
        w[ptb_pkg::POS_PRESC +: 2] = s.presc_sel;
        w[ptb_pkg::POS_MODE +: 2] = s.mode;
      end
      ptb_pkg::OFS_CTRL_B: begin
        w[ptb_pkg::POS_RUN] = s.run;
        w[ptb_pkg::POS_DIR] = s.dir;
      end
      ptb_pkg::OFS_PER_LO: w[7:0] = s.per_buf[7:0];
      ptb_pkg::OFS_PER_HI: w[3:0] = s.per_buf[11:8];
      ptb_pkg::OFS_COUNT: w[11:0] = s.count;
      ptb_pkg::OFS_STATUS: w[ptb_pkg::POS_IRQ] = s.irq;
      ptb_pkg::OFS_PER_ACT: w[11:0] = s.per_act;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a == ptb_pkg::OFS_CTRL_A) || (a == ptb_pkg::OFS_CTRL_B) ||
           (a == ptb_pkg::OFS_PER_LO) || (a == ptb_pkg::OFS_PER_HI) ||
           (a == ptb_pkg::OFS_COUNT) || (a == ptb_pkg::OFS_STATUS) ||
           (a == ptb_pkg::OFS_PER_ACT);
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic tick;
    logic updown;
    logic at_per;
    logic at_zero;
    logic ev_raw;
    logic ev_post;
    logic ev_irq;
    logic wr;
    logic setup;
    logic clr_scal;
    logic clr_irq;
    tick = 1'b0;
    updown = cur_ff.mode[1];
    at_per = cur_ff.count == cur_ff.per_act;
    at_zero = cur_ff.count == 12'h000;
    ev_raw = 1'b0;
    ev_post = 1'b0;
    ev_irq = 1'b0;
    clr_scal = 1'b0;
    clr_irq = 1'b0;
    nxt_st = cur_ff;
    nxt_st.zero_stb = 1'b0;
    nxt_st.per_stb = 1'b0;
    nxt_st.pready = 1'b0;
    nxt_st.slverr = 1'b0;
    setup = PSEL_IN && !PENABLE_IN && !cur_ff.pready;
    wr = PSEL_IN && PENABLE_IN && PWRITE_IN && cur_ff.pready;

    // prescaler
    if (cur_ff.run) begin
      tick = cur_ff.presc_cnt == ptb_pkg::ptb_presc_last(cur_ff.presc_sel);
      if (tick) begin
        nxt_st.presc_cnt = 6'h00;
      end else begin
        nxt_st.presc_cnt = cur_ff.presc_cnt + 6'h01;
      end
    end

    // counter
    if (tick && !updown) begin
      nxt_st.dir = 1'b0;
      if (at_per) begin
        nxt_st.count = 12'h000;
        nxt_st.per_act = cur_ff.per_buf;
        nxt_st.per_stb = 1'b1;
        ev_raw = 1'b1;
        if (cur_ff.mode == ptb_pkg::PTB_SINGLE) begin
          nxt_st.run = 1'b0;
        end
      end else begin
        nxt_st.count = cur_ff.count + 12'h001;
      end
      if (at_zero) begin
        nxt_st.zero_stb = 1'b1;
      end
    end else if (tick) begin
      if (at_zero) begin
        nxt_st.per_act = cur_ff.per_buf;
        nxt_st.zero_stb = 1'b1;
        ev_raw = 1'b1;
      end
      if (at_per) begin
        nxt_st.per_stb = 1'b1;
        if (cur_ff.mode == ptb_pkg::PTB_DOUBLE) begin
          ev_raw = 1'b1;
        end
      end
      if (!cur_ff.dir) begin
        if (at_per && !at_zero) begin
          nxt_st.dir = 1'b1;
          nxt_st.count = cur_ff.count - 12'h001;
          nxt_st.allow = 1'b1;
        end else if (!at_per) begin
          nxt_st.count = cur_ff.count + 12'h001;
        end
      end else begin
        if (at_zero) begin
          nxt_st.dir = 1'b0;
          if (!at_per) begin
            nxt_st.count = 12'h001;
          end
        end else begin
          nxt_st.count = cur_ff.count - 12'h001;
        end
      end
    end

    // stopped: count kept, period tracks its buffer
    if (!cur_ff.run) begin
      nxt_st.per_act = cur_ff.per_buf;
      nxt_st.allow = !updown;
    end

    // postscaler
    if (ev_raw) begin
      if (cur_ff.mode == ptb_pkg::PTB_SINGLE) begin
        ev_irq = 1'b1;
      end else begin
        ev_post = cur_ff.post_cnt == cur_ff.post_sel;
        ev_irq = ev_post;
        nxt_st.post_cnt = ev_post ? 4'h0 : cur_ff.post_cnt + 4'h1;
      end
    end

    // register writes
    if (wr) begin
      unique case (PADDR_IN)
        ptb_pkg::OFS_CTRL_A: begin
          nxt_st.post_sel = PWDATA_IN[ptb_pkg::POS_POST +: 4];
          nxt_st.presc_sel = PWDATA_IN[ptb_pkg::POS_PRESC +: 2];
          nxt_st.mode = ptb_pkg::ptb_mode_t'(
            PWDATA_IN[ptb_pkg::POS_MODE +: 2]);
          clr_scal = 1'b1;
        end
        ptb_pkg::OFS_CTRL_B: begin
          nxt_st.run = PWDATA_IN[ptb_pkg::POS_RUN];
          clr_scal = 1'b1;
        end
        ptb_pkg::OFS_PER_LO: nxt_st.per_buf[7:0] = PWDATA_IN[7:0];
        ptb_pkg::OFS_PER_HI: nxt_st.per_buf[11:8] = PWDATA_IN[3:0];
        ptb_pkg::OFS_COUNT: begin
          nxt_st.count = PWDATA_IN[11:0];
          clr_scal = 1'b1;
        end
        ptb_pkg::OFS_STATUS: clr_irq = PWDATA_IN[ptb_pkg::POS_IRQ];
        default: clr_scal = 1'b0;
      endcase
    end
    if (wr && (PADDR_IN == ptb_pkg::OFS_PER_LO) && !cur_ff.run) begin
      nxt_st.per_act[7:0] = PWDATA_IN[7:0];
    end
    if (clr_scal) begin
      nxt_st.presc_cnt = 6'h00;
      nxt_st.post_cnt = 4'h0;
    end

    // sticky flag, set beats clear
    if (ev_irq) begin
      nxt_st.irq = 1'b1;
    end else if (clr_irq) begin
      nxt_st.irq = 1'b0;
    end

    // apb answer
    if (setup) begin
      nxt_st.pready = 1'b1;
      nxt_st.slverr = !mapped(PADDR_IN);
      nxt_st.prdata = PWRITE_IN ? 32'h0000_0000 : rd_word(cur_ff, PADDR_IN);
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN) begin
    if (!RSTN_IN) begin
      cur_ff <= '0;
      cur_ff.count <= ptb_pkg::RST_COUNT;
      cur_ff.per_buf <= ptb_pkg::RST_PERIOD;
      cur_ff.per_act <= ptb_pkg::RST_PERIOD;
      cur_ff.mode <= ptb_pkg::ptb_mode_t'(
        ptb_pkg::RST_CTRL_A[ptb_pkg::POS_MODE +: 2]);
      cur_ff.presc_sel <= ptb_pkg::RST_CTRL_A[ptb_pkg::POS_PRESC +: 2];
      cur_ff.post_sel <= ptb_pkg::RST_CTRL_A[ptb_pkg::POS_POST +: 4];
      cur_ff.allow <= 1'b1;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign PRDATA_OUT = cur_ff.prdata;
  assign PREADY_OUT = cur_ff.pready;
  assign PSLVERR_OUT = cur_ff.slverr;
  assign COUNT_OUT = cur_ff.count;
  assign COUNT_DOWN_OUT = cur_ff.dir;
  assign ZERO_MATCH_OUT = cur_ff.zero_stb;
  assign PERIOD_MATCH_OUT = cur_ff.per_stb;
  assign OUTPUT_ALLOW_OUT = cur_ff.allow;
  assign IRQ_FLAG_OUT = cur_ff.irq;

endmodule // ptb_timebase

// File: design/ptb_pkg.sv
// package for the pwm time base: register map, fields, resets, encodings
// assumes a 32-bit apb slave with each register on one aligned word
package ptb_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_PER_LO = 8'h08;
  localparam logic [7:0] OFS_PER_HI = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_PER_ACT = 8'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_POST = 4;
  localparam int POS_PRESC = 2;
  localparam int POS_MODE = 0;
  localparam int POS_RUN = 7;
  localparam int POS_DIR = 6;
  localparam int POS_IRQ = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CTRL_A = 8'h00;
  localparam logic [11:0] RST_PERIOD = 12'h000;
  localparam logic [11:0] RST_COUNT = 12'h000;

  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PTB_FREE, PTB_SINGLE, PTB_UPDOWN, PTB_DOUBLE
  } ptb_mode_t;

  // last prescaler count for a select code
  function automatic logic [5:0] ptb_presc_last(input logic [1:0] sel);
    unique case (sel)
      2'b00: ptb_presc_last = 6'h00;
      2'b01: ptb_presc_last = 6'h03;
      2'b10: ptb_presc_last = 6'h0F;
      2'b11: ptb_presc_last = 6'h3F;
    endcase
  endfunction

endpackage

// File: verification/ptb_asserts.sv
// port checker for the pwm time base
// assumes bind onto ptb_timebase, one clock, sync active-low reset
`timescale 1ns/100ps
module ptb_asserts (
  // clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RSTN_IN,
  // apb
  input wire logic [7:0] PADDR_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  // time base
  input wire logic [11:0] COUNT_OUT,
  input wire logic COUNT_DOWN_OUT,
  input wire logic ZERO_MATCH_OUT,
  input wire logic PERIOD_MATCH_OUT,
  input wire logic OUTPUT_ALLOW_OUT,
  input wire logic IRQ_FLAG_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  // flag clear commit
  wire clr = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN &&
    PWDATA_IN[0] && PADDR_IN == ptb_pkg::OFS_STATUS;
  sequence s_acc;
    PSEL_IN && PENABLE_IN;
  endsequence
  pready_pulse_a: assert property (PREADY_OUT |-> s_acc ##1 !PREADY_OUT)
    else $error("pready not a single access pulse");
  slverr_map_a: assert property (
    PREADY_OUT |-> PSLVERR_OUT ==
    (PADDR_IN[1:0] != 2'b00 || PADDR_IN > ptb_pkg::OFS_PER_ACT))
    else $error("pslverr wrong for address");
  down_step_a: assert property (
    COUNT_DOWN_OUT && $past(COUNT_DOWN_OUT) && !$past(PSEL_IN) &&
    $changed(COUNT_OUT) |-> COUNT_OUT == $past(COUNT_OUT) - 12'h001)
    else $error("count not stepping down");
  up_step_a: assert property (
    !COUNT_DOWN_OUT && !$past(COUNT_DOWN_OUT) && !$past(PSEL_IN) &&
    $changed(COUNT_OUT) |->
    COUNT_OUT == $past(COUNT_OUT) + 12'h001 || COUNT_OUT == 12'h000)
    else $error("count not stepping up");
  zero_evt_a: assert property (
    ZERO_MATCH_OUT |-> $past(COUNT_OUT) == 12'h000 ||
    $past(COUNT_OUT, 2) == 12'h000)
    else $error("zero match without zero count");
  irq_cause_a: assert property (
    $rose(IRQ_FLAG_OUT) |-> ZERO_MATCH_OUT || PERIOD_MATCH_OUT ||
    $past(ZERO_MATCH_OUT || PERIOD_MATCH_OUT))
    else $error("flag set without event");
  irq_sticky_a: assert property (
    IRQ_FLAG_OUT && !clr |=> IRQ_FLAG_OUT)
    else $error("flag dropped without clear");
  allow_down_a: assert property (
    $rose(COUNT_DOWN_OUT) |-> ##[0:1] OUTPUT_ALLOW_OUT)
    else $error("outputs not allowed at count down");
endmodule // ptb_asserts

bind ptb_timebase ptb_asserts u_ptb_asserts (
  .CORE_CLK_IN(CORE_CLK_IN), .RSTN_IN(RSTN_IN), .PADDR_IN(PADDR_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN),
  .PWDATA_IN(PWDATA_IN), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .COUNT_OUT(COUNT_OUT),
  .COUNT_DOWN_OUT(COUNT_DOWN_OUT), .ZERO_MATCH_OUT(ZERO_MATCH_OUT),
  .PERIOD_MATCH_OUT(PERIOD_MATCH_OUT),
  .OUTPUT_ALLOW_OUT(OUTPUT_ALLOW_OUT), .IRQ_FLAG_OUT(IRQ_FLAG_OUT));

// File: verification/ptb_duty_model.sv
// duty compare stand-in fed by the time base
// assumes count and allow straight from ptb_timebase
`timescale 1ns/100ps
module ptb_duty_model #(
  parameter logic [11:0] DUTY = 12'h002
) (
  input wire logic [11:0] count_in,
  input wire logic allow_in,
  output logic pwm_out
);
  assign pwm_out = allow_in && count_in < DUTY;
endmodule // ptb_duty_model

// File: verification/tb_pwm_timebase_updown_period.sv
// self-checking bench for the pwm time base
// assumes ptb_timebase, ptb_duty_model and the bound checker
`timescale 1ns/100ps
module tb_pwm_timebase_updown_period;
  logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, perr, dwn, zm, pm, allow, flag, pwm;
  logic [11:0] cnt, c0;
  int err_total = 0, n_tests = 0, cyc;
  always #50 clk = ~clk;
  ptb_timebase u_ptb_timebase (
    .CORE_CLK_IN(clk), .RSTN_IN(rstn), .PADDR_IN(paddr), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(perr),
    .COUNT_OUT(cnt), .COUNT_DOWN_OUT(dwn), .ZERO_MATCH_OUT(zm),
    .PERIOD_MATCH_OUT(pm), .OUTPUT_ALLOW_OUT(allow), .IRQ_FLAG_OUT(flag));
  ptb_duty_model u_ptb_duty_model (
    .count_in(cnt), .allow_in(allow), .pwm_out(pwm));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [11:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {20'h0_0000, d};
    @(posedge clk);
    pen <= 1'b1;
    // request stands until pready is seen high at a rising edge
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wait_ev(input logic z, output int c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while ((z ? zm : pm) !== 1'b1);
  endtask
  task automatic setup(input logic [7:0] ca, input logic [11:0] p);
    apb(1'b1, 8'h04, 12'h000);
    apb(1'b1, 8'h00, {4'h0, ca});
    apb(1'b1, 8'h08, {4'h0, p[7:0]});
    apb(1'b1, 8'h0C, {8'h00, p[11:8]});
    apb(1'b1, 8'h10, 12'h000);
    apb(1'b1, 8'h14, 12'h001);
    apb(1'b1, 8'h04, 12'h080);
  endtask
  task automatic t_regs();
    for (int a = 0; a < 28; a += 4) begin
      apb(1'b0, a[7:0], 12'h000);
      chk(rd, 32'h0000_0000);
    end
    apb(1'b0, 8'h40, 12'h000);
    chk({rd[30:0], er}, 32'h0000_0001);
    apb(1'b1, 8'h08, 12'h034);
    apb(1'b1, 8'h0C, 12'h0F2);
    apb(1'b0, 8'h18, 12'h000);
    chk(rd, 32'h0000_0234);
  endtask
  task automatic t_free();
    for (int s = 0; s < 4; s++) begin
      setup({4'h1, s[1:0], 2'b00}, 12'h005);
      wait_ev(1'b0, cyc);
      wait_ev(1'b0, cyc);
      chk(cyc, 6 << (2 * s));
    end
    setup(8'h10, 12'h005);
    wait_ev(1'b0, cyc);
    repeat (2) @(negedge clk);
    chk(flag, 1'b0);
    wait_ev(1'b0, cyc);
    repeat (2) @(negedge clk);
    chk(flag, 1'b1);
  endtask
  task automatic t_single();
    setup(8'hF1, 12'h003);
    wait_ev(1'b0, cyc);
    repeat (8) @(negedge clk);
    chk(flag, 1'b1);
    chk(cnt, 12'h000);
    apb(1'b0, 8'h04, 12'h000);
    chk(rd, 32'h0000_0000);
  endtask
  task automatic t_hold();
    setup(8'h0C, 12'hFFF);
    repeat (200) @(negedge clk);
    apb(1'b1, 8'h00, 12'h00C);
    @(negedge clk);
    c0 = cnt;
    chk(c0 != 12'h000, 1'b1);
    repeat (58) @(negedge clk);
    chk(cnt, c0);
    repeat (10) @(negedge clk);
    chk(cnt, c0 + 12'h001);
    apb(1'b1, 8'h04, 12'h000);
    @(negedge clk);
    c0 = cnt;
    repeat (100) @(negedge clk);
    apb(1'b0, 8'h10, 12'h000);
    chk(rd, {20'h0_0000, c0});
  endtask
  task automatic t_updown();
    setup(8'h0A, 12'h004);
    @(negedge clk);
    chk({allow, pwm}, 2'b00);
    cyc = 0;
    while (dwn !== 1'b1) begin
      @(negedge clk);
      cyc++;
    end
    chk(cnt, 12'h003);
    apb(1'b0, 8'h04, 12'h000);
    chk(rd, 32'h0000_00C0);
    chk(allow, 1'b1);
    wait_ev(1'b1, cyc);
    chk({dwn, pwm}, 2'b01);
    wait_ev(1'b1, cyc);
    chk(cyc, 128);
    apb(1'b1, 8'h08, 12'h006);
    wait_ev(1'b1, cyc);
    wait_ev(1'b1, cyc);
    chk(cyc, 192);
  endtask
  task automatic t_evt(input logic [7:0] ca, input logic e);
    setup(ca, 12'h004);
    wait_ev(1'b1, cyc);
    repeat (3) @(negedge clk);
    apb(1'b1, 8'h14, 12'h001);
    @(negedge clk);
    chk(flag, 1'b0);
    wait_ev(1'b0, cyc);
    repeat (2) @(negedge clk);
    chk(flag, e);
    wait_ev(1'b1, cyc);
    repeat (2) @(negedge clk);
    chk(flag, 1'b1);
  endtask
  task automatic report_and_stop();
    $display("mismatches %0d, checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_free();
    t_single();
    t_hold();
    t_updown();
    t_evt(8'h06, 1'b0);
    t_evt(8'h07, 1'b1);
    report_and_stop();
  end
endmodule // tb_pwm_timebase_updown_period
